// File: rtl/ees_slave.sv
// two-wire serial eeprom slave: byte write, polling, three read kinds
// assumes scl and sda pins are asynchronous and far slower than sys_clk
`timescale 1ns/1ps
module ees_slave
  import ees_pkg::*;
#(
  parameter int PROG_CYCLES = `EES_PROG_CYCLES
)
(
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  input  wire logic sclIn,
  input  wire logic sdaIn,
  output logic      sdaOut,
  output logic      sdaOe,
  output logic      busy
);

  localparam int AW = `EES_ADDR_W;
  localparam logic [AW-1:0] PAGE_MASK = AW'(`EES_PAGE_BYTES - 1);
  localparam logic [`EES_PROG_W-1:0] PROG_LAST = `EES_PROG_W'(PROG_CYCLES - 1);

  ees_st_type             st_r;     // registered state
  ees_st_type             st_nxt;   // next state
  logic [1:0]             pinSync;  // synchronised scl, sda
  logic                   scl;      // synchronised clock line
  logic                   sda;      // synchronised data line
  logic                   sclRise;  // rising scl seen
  logic                   sclFall;  // falling scl seen
  logic                   startSeen;// start condition
  logic                   stopSeen; // stop condition
  logic [`EES_DATA_W-1:0] memRd;    // byte at word address counter

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // read roll-over: whole array
  function automatic logic [AW-1:0] readNext(input logic [AW-1:0] a);
    readNext = a + AW'(1);
  endfunction

  // write roll-over: stays inside the page
  function automatic logic [AW-1:0] writeNext(input logic [AW-1:0] a);
    logic [AW-1:0] inc;
    inc = a + AW'(1);
    writeNext = (a & ~PAGE_MASK) | (inc & PAGE_MASK);
  endfunction

  // states that shift a byte in from the master
  function automatic logic isRx(input ees_state_type s);
    isRx = (s == EES_DEV) || (s == EES_WADDR) || (s == EES_WDATA);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // pin synchroniser, idle bus is high
  ees_sync #(
    .WIDTH   (2),
    .RST_VAL (2'h3)
  ) u_sync (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .pinIn   ({sclIn, sdaIn}),
    .syncOut (pinSync)
  );

  assign scl = pinSync[1];
  assign sda = pinSync[0];

  ////////////////////////////////////////////////////////////////////////
  // storage array
  ees_mem #(
    .DEPTH  (`EES_DEPTH),
    .ADDR_W (AW),
    .DATA_W (`EES_DATA_W)
  ) u_mem (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .wrEn    (st_r.memWe),
    .wrAddr  (st_r.pendAddr),
    .wrData  (st_r.pendData),
    .rdAddr  (st_r.wordAddr),
    .rdData  (memRd)
  );

  ////////////////////////////////////////////////////////////////////////
  // line events
  assign sclRise   = scl & ~st_r.sclPrev;
  assign sclFall   = ~scl & st_r.sclPrev;
  assign startSeen = scl & st_r.sclPrev & st_r.sdaPrev & ~sda;
  assign stopSeen  = scl & st_r.sclPrev & ~st_r.sdaPrev & sda;

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    st_nxt         = st_r;
    st_nxt.sclPrev = scl;
    st_nxt.sdaPrev = sda;
    st_nxt.memWe   = 1'b0;
    st_nxt.sdaOut  = 1'b0;
    if (st_r.state == EES_PROG)
    begin
      // bus fully ignored while programming
      st_nxt.drive = 1'b0;
      if (st_r.progCnt == '0)
      begin
        // cycle over: commit byte, back to standby
        st_nxt.memWe     = 1'b1;
        st_nxt.busy      = 1'b0;
        st_nxt.pendValid = 1'b0;
        st_nxt.state     = EES_IDLE;
      end
      else
      begin
        st_nxt.progCnt = st_r.progCnt - `EES_PROG_W'(1);
      end
    end
    else if (startSeen)
    begin
      // start or repeated start: expect address byte
      st_nxt.state    = EES_DEV;
      st_nxt.bitCnt   = '0;
      st_nxt.ackPhase = 1'b0;
      st_nxt.drive    = 1'b0;
    end
    else if (stopSeen)
    begin
      // stop releases the line, launches pending write
      st_nxt.drive    = 1'b0;
      st_nxt.ackPhase = 1'b0;
      if (st_r.pendValid)
      begin
        st_nxt.state   = EES_PROG;
        st_nxt.busy    = 1'b1;
        st_nxt.progCnt = PROG_LAST;
      end
      else
      begin
        st_nxt.state = EES_IDLE;
      end
    end
    else if (isRx(st_r.state))
    begin
      if (sclRise && st_r.bitCnt < `EES_ACK_SLOT)
      begin
        // sample a bit on rising scl, msb first
        st_nxt.rxShift = {st_r.rxShift[`EES_DATA_W-2:0], sda};
        st_nxt.bitCnt  = st_r.bitCnt + 4'h1;
      end
      else if (sclFall && st_r.bitCnt == `EES_ACK_SLOT && !st_r.ackPhase)
      begin
        // byte complete: decide acknowledge
        st_nxt.ackPhase = 1'b1;
        case (st_r.state)
          EES_DEV:
          begin
            if (st_r.rxShift[7:1] == {`EES_TYPE_CODE, `EES_FIXED_BITS})
            begin
              st_nxt.drive = 1'b1;
            end
            else
            begin
              st_nxt.state = EES_IDLE;
            end
          end
          EES_WADDR:
          begin
            // word address loaded into counter
            st_nxt.drive    = 1'b1;
            st_nxt.wordAddr = st_r.rxShift[AW-1:0];
          end
          EES_WDATA:
          begin
            // data held until the stop, counter moves in page
            st_nxt.drive     = 1'b1;
            st_nxt.pendAddr  = st_r.wordAddr;
            st_nxt.pendData  = st_r.rxShift;
            st_nxt.pendValid = 1'b1;
            st_nxt.wordAddr  = writeNext(st_r.wordAddr);
          end
          default:
          begin
            st_nxt.state = EES_IDLE;
          end
        endcase
      end
      else if (sclFall && st_r.ackPhase)
      begin
        // end of ninth clock: release and move on
        st_nxt.drive    = 1'b0;
        st_nxt.ackPhase = 1'b0;
        st_nxt.bitCnt   = '0;
        case (st_r.state)
          EES_DEV:
          begin
            if (st_r.rxShift[0] == `EES_RW_READ)
            begin
              // first read byte, msb driven now
              st_nxt.state    = EES_RDATA;
              st_nxt.txShift  = {memRd[`EES_DATA_W-2:0], 1'b0};
              st_nxt.drive    = ~memRd[`EES_DATA_W-1];
              st_nxt.wordAddr = readNext(st_r.wordAddr);
            end
            else
            begin
              st_nxt.state = EES_WADDR;
            end
          end
          EES_WADDR:
          begin
            st_nxt.state = EES_WDATA;
          end
          default:
          begin
            // further data bytes replace the held one
            st_nxt.state = EES_WDATA;
          end
        endcase
      end
    end
    else
    begin
      case (st_r.state)
        EES_RDATA:
        begin
          if (sclRise)
          begin
            st_nxt.bitCnt = st_r.bitCnt + 4'h1;
          end
          else if (sclFall && st_r.bitCnt == `EES_ACK_SLOT)
          begin
            // hand the ack slot to the master
            st_nxt.drive   = 1'b0;
            st_nxt.ackSeen = 1'b0;
            st_nxt.state   = EES_RACK;
          end
          else if (sclFall)
          begin
            // next bit after falling scl
            st_nxt.drive   = ~st_r.txShift[`EES_DATA_W-1];
            st_nxt.txShift = {st_r.txShift[`EES_DATA_W-2:0], 1'b0};
          end
        end
        EES_RACK:
        begin
          if (sclRise)
          begin
            if (sda)
            begin
              // nack: stop driving, wait for stop
              st_nxt.state = EES_IDLE;
            end
            else
            begin
              st_nxt.ackSeen = 1'b1;
            end
          end
          else if (sclFall && st_r.ackSeen)
          begin
            // master acked: next sequential byte
            st_nxt.state    = EES_RDATA;
            st_nxt.bitCnt   = '0;
            st_nxt.txShift  = {memRd[`EES_DATA_W-2:0], 1'b0};
            st_nxt.drive    = ~memRd[`EES_DATA_W-1];
            st_nxt.wordAddr = readNext(st_r.wordAddr);
          end
        end
        EES_IDLE:
        begin
          st_nxt.drive = 1'b0;
        end
        default:
        begin
          st_nxt.state = EES_IDLE;
          st_nxt.drive = 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register, counter survives across transfers
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_r           <= '0;
      st_r.state     <= EES_IDLE;
      st_r.sclPrev   <= 1'b1;
      st_r.sdaPrev   <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs straight from the state register
  assign sdaOut = st_r.sdaOut;
  assign sdaOe  = st_r.drive;
  assign busy   = st_r.busy;
endmodule

// File: rtl/ees_defines.svh
// constants for the two-wire serial eeprom slave
// assumes inclusion by the package and by design modules
`ifndef EES_DEFINES_SVH
`define EES_DEFINES_SVH

// storage geometry
`define EES_DATA_W      8
`define EES_ADDR_W      7
`define EES_DEPTH       128
`define EES_PAGE_BYTES  8

// device address byte: type code, fixed zero bits, read select
`define EES_TYPE_CODE   4'ha
`define EES_FIXED_BITS  3'h0
`define EES_RW_READ     1'h1

// bit counter value at the acknowledge clock
`define EES_ACK_SLOT    4'h8

// default programming time in device clock cycles
`define EES_PROG_CYCLES 1000
`define EES_PROG_W      16

`endif

// File: rtl/ees_pkg.sv
// types for the two-wire serial eeprom slave
// assumes ees_defines.svh is on the include path
package ees_pkg;
  `include "ees_defines.svh"

  // protocol states, one-hot
  typedef enum logic [6:0]
  {
    EES_IDLE  = 7'h01,
    EES_DEV   = 7'h02,
    EES_WADDR = 7'h04,
    EES_WDATA = 7'h08,
    EES_RDATA = 7'h10,
    EES_RACK  = 7'h20,
    EES_PROG  = 7'h40
  } ees_state_type;

  // whole state of the slave
  typedef struct packed
  {
    ees_state_type                state;     // protocol state
    logic                         sclPrev;   // scl one cycle ago
    logic                         sdaPrev;   // sda one cycle ago
    logic [3:0]                   bitCnt;    // bits of the current byte
    logic                         ackPhase;  // inside the acknowledge clock
    logic [`EES_DATA_W-1:0]       rxShift;   // incoming byte
    logic [`EES_DATA_W-1:0]       txShift;   // outgoing byte
    logic [`EES_ADDR_W-1:0]       wordAddr;  // word address counter
    logic [`EES_ADDR_W-1:0]       pendAddr;  // address to program
    logic [`EES_DATA_W-1:0]       pendData;  // byte to program
    logic                         pendValid; // a byte awaits programming
    logic                         ackSeen;   // master acked a read byte
    logic                         drive;     // pulling sda low
    logic                         sdaOut;    // open-drain level, always low
    logic                         busy;      // programming cycle running
    logic [`EES_PROG_W-1:0]       progCnt;   // programming time left
    logic                         memWe;     // array write strobe
  } ees_st_type;
endpackage

// File: rtl/ees_sync.sv
// two-flop synchroniser for a vector of pin inputs
// assumes inputs are asynchronous to sys_clk
`timescale 1ns/1ps
module ees_sync
#(
  parameter int         WIDTH   = 2,
  parameter logic [1:0] RST_VAL = 2'h3
)
(
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] meta_r; // first stage, read only by the second

  ////////////////////////////////////////////////////////////////////////
  // both stages reset to the idle bus level
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      meta_r  <= RST_VAL[WIDTH-1:0];
      syncOut <= RST_VAL[WIDTH-1:0];
    end
    else
    begin
      meta_r  <= pinIn;
      syncOut <= meta_r;
    end
  end
endmodule

// File: rtl/ees_mem.sv
// byte array with one write port and a registered read port
// assumes write and read addresses are stable around their use
`timescale 1ns/1ps
module ees_mem
#(
  parameter int DEPTH  = 128,
  parameter int ADDR_W = 7,
  parameter int DATA_W = 8
)
(
  input  wire logic              sys_clk,
  input  wire logic              sys_rst,
  input  wire logic              wrEn,
  input  wire logic [ADDR_W-1:0] wrAddr,
  input  wire logic [DATA_W-1:0] wrData,
  input  wire logic [ADDR_W-1:0] rdAddr,
  output logic      [DATA_W-1:0] rdData
);

  logic [DATA_W-1:0] mem [DEPTH]; // storage cells, no reset

  ////////////////////////////////////////////////////////////////////////
  // array write
  always_ff @(posedge sys_clk)
  begin
    if (wrEn)
    begin
      mem[wrAddr] <= wrData;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registered read
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rdData <= '0;
    end
    else
    begin
      rdData <= mem[rdAddr];
    end
  end
endmodule

// File: dv/ees_slave_chk.sv
// checker for the eeprom slave pins
// assumes binding onto ees_slave, one clock domain
`timescale 1ns/1ps
module ees_slave_chk
#(
  parameter int PROG_CYCLES = 10
)
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic sclIn,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic busy
);
  logic [15:0] busyCnt_r; // cycles of busy so far

  // counts the length of a programming cycle
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      busyCnt_r <= 16'h0;
    else if (busy)
      busyCnt_r <= busyCnt_r + 16'h1;
    else
      busyCnt_r <= 16'h0;
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence progRun;
    busy[*8];
  endsequence
  sequence driveStand;
    sdaOe[*6];
  endsequence

  a_od_level_low: assert property (sdaOe |-> sdaOut == 1'b0)
    else $error("sda driven high");
  a_oe_scl_low: assert property ($changed(sdaOe) |-> !sclIn)
    else $error("sda drive changed with scl high");
  a_drive_min_len: assert property ($rose(sdaOe) |-> driveStand)
    else $error("sda drive too short");
  a_drive_bounded: assert property ($rose(sdaOe) |-> ##[1:80] !sdaOe)
    else $error("sda drive never released");
  a_busy_quiet: assert property (busy |-> !sdaOe)
    else $error("slave answered while programming");
  a_busy_exact_len: assert property ($fell(busy) |-> busyCnt_r == PROG_CYCLES)
    else $error("programming time wrong");
  a_busy_min_run: assert property ($rose(busy) |-> progRun)
    else $error("programming cycle cut short");
  a_busy_on_stop: assert property ($rose(busy) |-> sclIn && sdaIn && $past(sclIn, 2))
    else $error("programming began outside a stop");
endmodule

bind ees_slave ees_slave_chk #(.PROG_CYCLES(PROG_CYCLES)) ees_slave_chk_inst
(
  .sys_clk(sys_clk),
  .sys_rst(sys_rst),
  .sclIn  (sclIn),
  .sdaIn  (sdaIn),
  .sdaOut (sdaOut),
  .sdaOe  (sdaOe),
  .busy   (busy)
);

// File: dv/ees_master.sv
// two-wire bus master model, 320 ns bus clock
// assumes sdaLine is the resolved wired line with pull-up
`timescale 1ns/1ps
module ees_master
(
  input  wire logic sys_clk,
  input  wire logic sdaLine,
  output logic      sclPin,
  output logic      sdaPull
);
  // bus idle, scl stands high outside frames
  initial
  begin
    sclPin = 1'b1;
    sdaPull = 1'b0;
  end

  // a quarter of the bus clock period
  task automatic quarter();
    repeat (2) @(posedge sys_clk);
  endtask

  // sda falls while scl high
  task automatic bus_start();
    sdaPull <= 1'b0;
    quarter();
    sclPin <= 1'b1;
    quarter();
    sdaPull <= 1'b1;
    quarter();
    sclPin <= 1'b0;
    quarter();
  endtask

  // sda rises while scl high
  task automatic bus_stop();
    sdaPull <= 1'b1;
    quarter();
    sclPin <= 1'b1;
    quarter();
    sdaPull <= 1'b0;
    quarter();
    quarter();
  endtask

  // byte out msb first, data moves only with scl low
  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      sdaPull <= ~b[i];
      quarter();
      sclPin <= 1'b1;
      quarter();
      quarter();
      sclPin <= 1'b0;
      quarter();
    end
    sdaPull <= 1'b0;
    quarter();
    sclPin <= 1'b1;
    quarter();
    ack = ~sdaLine;
    quarter();
    sclPin <= 1'b0;
    quarter();
  endtask

  // byte in, then ack or leave the slot high
  task automatic get_byte(input logic ackIt, output logic [7:0] b);
    sdaPull <= 1'b0;
    for (int i = 7; i >= 0; i--)
    begin
      // scl low for two quarters: slave moves sda three cycles after the fall
      quarter();
      quarter();
      sclPin <= 1'b1;
      quarter();
      b[i] = sdaLine;
      quarter();
      sclPin <= 1'b0;
    end
    quarter();
    sdaPull <= ackIt;
    quarter();
    sclPin <= 1'b1;
    quarter();
    quarter();
    sclPin <= 1'b0;
    quarter();
  endtask
endmodule

// File: dv/ees_slave_test.sv
// self-checking bench for the eeprom slave
// assumes ees_master drives the bus, checker bound to ees_slave
`timescale 1ns/1ps
module ees_slave_test;
  localparam int PROG = 150; // long enough that the first poll lands inside it
  logic       sys_clk;
  logic       sys_rst;
  logic       sclPin;
  logic       sdaPull;
  logic       sdaLine;
  logic       sdaOut;
  logic       sdaOe;
  logic       busy;
  logic [7:0] expMem [128]; // expected array
  logic [6:0] expCnt;       // expected address counter
  int         nFail;
  int         numChecks;
  int         cycles;

  // wired line with pull-up
  assign sdaLine = (sdaOe ? sdaOut : 1'b1) & ~sdaPull;

  ees_slave #(.PROG_CYCLES(PROG)) ees_slave_inst
  (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .sclIn  (sclPin),
    .sdaIn  (sdaLine),
    .sdaOut (sdaOut),
    .sdaOe  (sdaOe),
    .busy   (busy)
  );
  ees_master ees_master_inst
  (
    .sys_clk(sys_clk),
    .sdaLine(sdaLine),
    .sclPin (sclPin),
    .sdaPull(sdaPull)
  );

  ////////////////////////////////////////////////////////////////
  always #20 sys_clk = ~sys_clk;

  // hang guard
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      nFail++;
      completeRun();
    end
  end

  task automatic completeRun();
    $display("checks %0d failures %0d", numChecks, nFail);
    if (nFail == 0 && numChecks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] expV, input logic [7:0] gotV);
    numChecks++;
    if (gotV !== expV)
    begin
      nFail++;
      $display("[ERR] %s expected %h seen %h", what, expV, gotV);
    end
  endtask

  ////////////////////////////////////////////////////////////////
  // byte write, optional second byte, then polling
  task automatic wr(input logic [6:0] a, input logic [7:0] d, input logic [7:0] d2, input logic two);
    logic       ack;
    logic [6:0] w;
    w = a;
    ees_master_inst.bus_start();
    ees_master_inst.put_byte(8'ha0, ack);
    chk("device ack", 8'h01, {7'h0, ack});
    ees_master_inst.put_byte({1'b0, a}, ack);
    chk("word ack", 8'h01, {7'h0, ack});
    ees_master_inst.put_byte(d, ack);
    chk("data ack", 8'h01, {7'h0, ack});
    if (two)
    begin
      w = {a[6:3], a[2:0] + 3'h1};
      ees_master_inst.put_byte(d2, ack);
      chk("second data ack", 8'h01, {7'h0, ack});
    end
    expMem[w] = two ? d2 : d;
    expCnt = {w[6:3], w[2:0] + 3'h1};
    ees_master_inst.bus_stop();
    @(negedge sys_clk);
    chk("busy after stop", 8'h01, {7'h0, busy});
    ees_master_inst.bus_start();
    ees_master_inst.put_byte(8'ha0, ack);
    chk("poll while busy", 8'h00, {7'h0, ack});
    ees_master_inst.bus_stop();
    // keep polling until the slave answers again, bounded
    for (int i = 0; i < 4 && !ack; i++)
    begin
      ees_master_inst.bus_start();
      ees_master_inst.put_byte(8'ha0, ack);
      ees_master_inst.bus_stop();
    end
    chk("poll after cycle", 8'h01, {7'h0, ack});
  endtask

  // random or current read of n bytes
  task automatic rd(input logic [6:0] a, input logic rnd, input int n);
    logic       ack;
    logic [7:0] b;
    logic [6:0] p;
    p = rnd ? a : expCnt;
    if (rnd)
    begin
      ees_master_inst.bus_start();
      ees_master_inst.put_byte(8'ha0, ack);
      ees_master_inst.put_byte({1'b0, a}, ack);
      chk("dummy write ack", 8'h01, {7'h0, ack});
    end
    ees_master_inst.bus_start();
    ees_master_inst.put_byte(8'ha1, ack);
    chk("read address ack", 8'h01, {7'h0, ack});
    for (int i = 0; i < n; i++)
    begin
      ees_master_inst.get_byte(i != n - 1, b);
      chk("read data", expMem[p], b);
      p = p + 7'h1;
    end
    expCnt = p;
    ees_master_inst.bus_stop();
    @(negedge sys_clk);
    chk("released after stop", 8'h00, {7'h0, sdaOe});
  endtask

  // foreign device addresses get no ack
  task automatic bad_addr();
    logic       ack;
    logic [7:0] codes [3];
    codes = '{8'hb0, 8'ha2, 8'h20};
    for (int i = 0; i < 3; i++)
    begin
      ees_master_inst.bus_start();
      ees_master_inst.put_byte(codes[i], ack);
      chk("foreign address nack", 8'h00, {7'h0, ack});
      ees_master_inst.bus_stop();
    end
  endtask

  ////////////////////////////////////////////////////////////////
  initial
  begin
    sys_clk = 1'b0;
    sys_rst = 1'b1;
    nFail = 0;
    numChecks = 0;
    cycles = 0;
    expCnt = 7'h0;
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("idle after reset", 8'h00, {6'h0, sdaOe, busy});
    wr(7'h00, 8'hc3, 8'h00, 1'b0);
    wr(7'h01, 8'h3c, 8'h00, 1'b0);
    wr(7'h7f, 8'h5a, 8'h00, 1'b0);
    rd(7'h00, 1'b1, 1);
    rd(7'h00, 1'b0, 1);
    rd(7'h7f, 1'b1, 3);
    bad_addr();
    wr(7'h0f, 8'h11, 8'h22, 1'b1);
    rd(7'h08, 1'b1, 1);
    completeRun();
  end
endmodule
